/* inc/flash_status_regs.svh */
/*
  command codes, status bit positions and reset values of the flash
  status and error logic. assumes nothing; definitions only.
*/
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

`define CMD_READ_ARRAY 8'hff
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_PROGRAM 8'h40
`define CMD_ERASE_SETUP 8'h20
`define CMD_ERASE_CONFIRM 8'hd0

`define STATUS_PROGRAM_FAIL_POS 4
`define STATUS_ERASE_FAIL_POS 5
`define STATUS_READY_POS 7
`define STATUS_RESERVED_VALUE 1'b0
`define READY_RESET 1'b1
`define ERROR_RESET 1'b0
`define BLOCK_SELECT_NONE 2'b00
`define FLAG_SET 1'b1
`define FLAG_CLEAR 1'b0
`define READY_BUSY 1'b0
`define STATUS_WIDTH 8

`endif

/* inc/flash_status_pkg.sv */
/*
  types shared by the flash status and error logic.
  assumes the command codes of flash_status_regs.svh.
*/
package flash_status_pkg;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_WAIT_PROGRAM_DATA = 2'b01,
    CMD_WAIT_ERASE_CONFIRM = 2'b11
  } cmd_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_ERASE = 2'b11
  } op_kind_t;

  // one bus write into the user rom area
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } bus_write_t;

  // start request to the flash array engine
  typedef struct packed {
    logic start;
    op_kind_t kind;
    logic [15:0] addr;
    logic [7:0] data;
  } op_start_t;

  // mirror bits of the flash control register
  typedef struct packed {
    logic erase_error_mirror;
    logic program_error_mirror;
    logic seq_ready_mirror;
  } status_mirror_t;

endpackage

/* design/flash_status_error_logic.sv */
/*
  status and error logic of the flash sequencer: decodes byte-wide
  software commands, tracks busy/ready, records failures and command
  sequence errors, and chooses status byte or array data for reads.
  assumes a flash array engine that reports done and fail for each
  started operation, and an address map that says whether an address
  is flash and which block it falls in. all inputs are on sys_clk.
*/
// Summary of operation
// - ready and error bits mirrored into control register
// - after read status, mode a reads give status
// - after program/erase, mode a reads give status
// - ready is 0 while busy, 1 at completion
// - status byte: d4 program, d5 erase, d7 ready
// - clear status zeroes both error flags
// - error flag set blocks program and erase commands
// - sequence error sets both error flags
// - bad command sequence flags sequence error
// - erase second byte not d0h/ffh is error
// - program/erase to block 0 while rewrite disabled is error
// - unmapped or locked target address is error
// - failed erase sets erase error only
// - failed program sets program error only
// - ffh in second cycle cancels, enters read array
`include "flash_status_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_status_error_logic #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire flash_status_pkg::bus_write_t cmd_write,
  input wire logic read_req,
  input wire logic [ADDR_W-1:0] read_addr,
  input wire logic read_addr_user_rom,
  input wire logic [7:0] array_data,
  input wire logic erase_write_mode_a,
  input wire logic rewrite_enable_bit,
  input wire logic block0_rewrite_lock,
  input wire logic block1_rewrite_lock,
  input wire logic target_is_flash,
  input wire logic [1:0] target_block,
  input wire logic op_done,
  input wire logic op_fail,
  output flash_status_pkg::op_start_t op_start,
  output logic [7:0] read_data,
  output logic [7:0] sequencer_status_byte,
  output flash_status_pkg::status_mirror_t flash_control_reg_a,
  output logic cmd_busy
);

  flash_status_pkg::cmd_state_t cmd_state;
  flash_status_pkg::cmd_state_t next_cmd_state;
  flash_status_pkg::op_kind_t op_kind;
  logic status_ready_bit;
  logic status_erase_fail_bit;
  logic status_program_fail_bit;
  logic status_read_mode;
  logic [ADDR_W-1:0] first_addr;
  logic [7:0] read_data_q;
  flash_status_pkg::op_start_t op_start_q;

  // write decode
  wire wr = cmd_write.valid;
  wire [7:0] wdata = cmd_write.data;
  wire in_idle = cmd_state == flash_status_pkg::CMD_IDLE;
  wire in_prog2 = cmd_state == flash_status_pkg::CMD_WAIT_PROGRAM_DATA;
  wire in_erase2 = cmd_state == flash_status_pkg::CMD_WAIT_ERASE_CONFIRM;
  wire any_error = status_erase_fail_bit | status_program_fail_bit;

  wire code_read_array = wdata == `CMD_READ_ARRAY;
  wire code_read_status = wdata == `CMD_READ_STATUS;
  wire code_clear = wdata == `CMD_CLEAR_STATUS;
  wire code_program = wdata == `CMD_PROGRAM;
  wire code_erase_setup = wdata == `CMD_ERASE_SETUP;
  wire code_erase_confirm = wdata == `CMD_ERASE_CONFIRM;

  // rewrite permission of the target block, one entry per lockable block
  localparam int LOCK_BLOCKS = 2;
  logic [LOCK_BLOCKS-1:0] block_lock;
  logic [LOCK_BLOCKS-1:0] block_hit;
  assign block_lock[0] = ~rewrite_enable_bit | block0_rewrite_lock;
  assign block_lock[1] = block1_rewrite_lock;
  genvar k;
  generate
    for (k = 0; k < LOCK_BLOCKS; k++) begin : g_block
      assign block_hit[k] = (target_block == 2'(k)) & block_lock[k];
    end
  endgenerate
  wire block_locked = |block_hit;
  wire target_bad = ~target_is_flash | block_locked;

  // first cycle
  wire status_ready_bit_n = ~status_ready_bit;
  wire idle_wr = wr & in_idle & ~status_ready_bit_n;
  wire first_known = code_read_array | code_read_status | code_clear |
                     code_program | code_erase_setup;
  wire first_bad = wr & in_idle & status_ready_bit & ~first_known;
  wire start_prog_cycle = idle_wr & code_program & ~any_error;
  wire start_erase_cycle = idle_wr & code_erase_setup & ~any_error;

  // second cycle
  wire second_wr = wr & (in_prog2 | in_erase2);
  wire second_cancel = second_wr & code_read_array;
  wire prog_addr_mismatch = cmd_write.addr != first_addr;
  wire prog_seq_bad = in_prog2 & (prog_addr_mismatch | target_bad);
  wire erase_code_bad = in_erase2 & ~code_erase_confirm;
  wire erase_seq_bad = in_erase2 & target_bad;
  wire second_err = second_wr & ~second_cancel &
                    (prog_seq_bad | erase_code_bad | erase_seq_bad);
  wire launch = second_wr & ~second_cancel & ~second_err;
  flash_status_pkg::op_kind_t launch_kind;
  assign launch_kind = in_prog2 ? flash_status_pkg::OP_PROGRAM : flash_status_pkg::OP_ERASE;

  wire seq_error = first_bad | second_err;
  wire clear_cmd = idle_wr & code_clear;
  wire finish = ~status_ready_bit & op_done;
  wire erase_fail = finish & op_fail & (op_kind == flash_status_pkg::OP_ERASE);
  wire prog_fail = finish & op_fail & (op_kind == flash_status_pkg::OP_PROGRAM);

  // command sequencer
  always_comb begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      flash_status_pkg::CMD_IDLE: begin
        if (start_prog_cycle) begin
          next_cmd_state = flash_status_pkg::CMD_WAIT_PROGRAM_DATA;
        end else if (start_erase_cycle) begin
          next_cmd_state = flash_status_pkg::CMD_WAIT_ERASE_CONFIRM;
        end
      end
      flash_status_pkg::CMD_WAIT_PROGRAM_DATA,
      flash_status_pkg::CMD_WAIT_ERASE_CONFIRM: begin
        if (second_wr) begin
          next_cmd_state = flash_status_pkg::CMD_IDLE;
        end
      end
      default: begin
        next_cmd_state = flash_status_pkg::CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_state <= flash_status_pkg::CMD_IDLE;
      first_addr <= '0;
    end else begin
      cmd_state <= next_cmd_state;
      if (start_prog_cycle) begin
        first_addr <= ADDR_W'(cmd_write.addr);
      end
    end
  end

  // busy/ready and operation kind
  logic next_ready;
  flash_status_pkg::op_kind_t next_op_kind;

  always_comb begin
    next_ready = status_ready_bit;
    next_op_kind = op_kind;
    if (launch) begin
      next_ready = `READY_BUSY;
      next_op_kind = launch_kind;
    end else if (finish) begin
      next_ready = `READY_RESET;
      next_op_kind = flash_status_pkg::OP_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_ready_bit <= `READY_RESET;
      op_kind <= flash_status_pkg::OP_NONE;
    end else begin
      status_ready_bit <= next_ready;
      op_kind <= next_op_kind;
    end
  end

  // error flags: a setting event wins over a clear in the same cycle
  logic next_erase_fail;
  logic next_program_fail;

  always_comb begin
    next_erase_fail = status_erase_fail_bit;
    next_program_fail = status_program_fail_bit;
    if (clear_cmd) begin
      next_erase_fail = `FLAG_CLEAR;
      next_program_fail = `FLAG_CLEAR;
    end
    if (seq_error | erase_fail) begin
      next_erase_fail = `FLAG_SET;
    end
    if (seq_error | prog_fail) begin
      next_program_fail = `FLAG_SET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_erase_fail_bit <= `ERROR_RESET;
      status_program_fail_bit <= `ERROR_RESET;
    end else begin
      status_erase_fail_bit <= next_erase_fail;
      status_program_fail_bit <= next_program_fail;
    end
  end

  // read mode: status after 70h or a launched operation, array after ffh
  wire enter_status = (idle_wr & code_read_status) | launch;
  wire enter_array = (idle_wr & code_read_array) | second_cancel;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_read_mode <= 1'b0;
    end else if (enter_status) begin
      status_read_mode <= 1'b1;
    end else if (enter_array) begin
      status_read_mode <= 1'b0;
    end
  end

  // status byte assembly
  wire [7:0] status_byte;
  genvar b;
  generate
    for (b = 0; b < `STATUS_WIDTH; b++) begin : g_status
      if (b == `STATUS_READY_POS) begin : g_rdy
        assign status_byte[b] = status_ready_bit;
      end else if (b == `STATUS_ERASE_FAIL_POS) begin : g_ers
        assign status_byte[b] = status_erase_fail_bit;
      end else if (b == `STATUS_PROGRAM_FAIL_POS) begin : g_prg
        assign status_byte[b] = status_program_fail_bit;
      end else begin : g_rsv
        assign status_byte[b] = `STATUS_RESERVED_VALUE;
      end
    end
  endgenerate

  // read path
  wire show_status = erase_write_mode_a & status_read_mode & read_addr_user_rom;
  wire [7:0] next_read_data = show_status ? status_byte : array_data;
  wire [ADDR_W-1:0] unused_read_addr = read_addr;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      read_data_q <= '0;
    end else if (read_req) begin
      read_data_q <= next_read_data;
    end
  end

  // start request to the array engine
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_start_q <= '0;
    end else begin
      op_start_q.start <= launch;
      op_start_q.kind <= launch_kind;
      op_start_q.addr <= cmd_write.addr;
      op_start_q.data <= wdata;
    end
  end

  assign op_start = op_start_q;
  assign read_data = read_data_q;
  assign sequencer_status_byte = status_byte;
  assign flash_control_reg_a.seq_ready_mirror = status_ready_bit;
  assign flash_control_reg_a.erase_error_mirror = status_erase_fail_bit;
  assign flash_control_reg_a.program_error_mirror = status_program_fail_bit;
  assign cmd_busy = ~status_ready_bit;

endmodule

`default_nettype wire

/* tb/flash_status_error_logic_properties.sv */
/*
  checker of the flash status and error logic, bound to its top.
  assumes the status byte and mirror layout of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_status_error_logic_properties (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire flash_status_pkg::bus_write_t cmd_write,
  input wire logic op_done,
  input wire logic op_fail,
  input wire flash_status_pkg::op_start_t op_start,
  input wire logic [7:0] sequencer_status_byte,
  input wire flash_status_pkg::status_mirror_t flash_control_reg_a
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic [7:0] s = sequencer_status_byte;
  wire logic err = s[5] | s[4];
  wire logic [7:0] d = cmd_write.data;
  wire logic wv = cmd_write.valid;
  logic [1:0] pend;
  logic last_erase;
  // 0 idle, 1 program data due, 2 erase confirm due
  always_ff @(posedge sys_clk) begin
    if (sys_rst) pend <= 2'd0;
    else if (wv) pend <= (pend != 2'd0 || !s[7] || err) ? 2'd0 :
      (d == 8'h20) ? 2'd2 : (d == 8'h40) ? 2'd1 : 2'd0;
    if (op_start.start) last_erase <= op_start.kind == flash_status_pkg::OP_ERASE;
  end
  sequence s_busy_done;
    !s[7] && op_done;
  endsequence
  sequence s_err_held;
    err [*2];
  endsequence
  property p_mirror;
    flash_control_reg_a == {s[5], s[4], s[7]};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror differs");
  property p_rsv;
    s[6] == 1'b0 && s[3:0] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_start;
    op_start.start |-> !s[7] && $past(s[7]);
  endproperty
  a_start: assert property (p_start) else $error("ready not low at start");
  property p_done;
    s_busy_done |=> s[7];
  endproperty
  a_done: assert property (p_done) else $error("ready not back");
  property p_efail;
    s_busy_done ##0 (op_fail && last_erase) |=> s[5];
  endproperty
  a_efail: assert property (p_efail) else $error("erase error lost");
  property p_pfail;
    s_busy_done ##0 (op_fail && !last_erase) |=> s[4];
  endproperty
  a_pfail: assert property (p_pfail) else $error("program error lost");
  property p_refuse;
    s_err_held |=> !op_start.start;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start with error");
  property p_hold;
    $fell(s[5]) || $fell(s[4]) |-> $past(wv && d == 8'h50);
  endproperty
  a_hold: assert property (p_hold) else $error("flag fell alone");
  property p_clear;
    wv && d == 8'h50 && pend == 2'd0 && s[7] && !op_done |=> !err;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
  property p_bad2;
    wv && pend == 2'd2 && d != 8'hd0 && d != 8'hff |=> s[5:4] == 2'b11;
  endproperty
  a_bad2: assert property (p_bad2) else $error("bad confirm unflagged");
  property p_bad1;
    wv && pend == 2'd0 && s[7] && !(d inside {8'hff, 8'h70, 8'h50, 8'h40, 8'h20})
      |=> s[5:4] == 2'b11;
  endproperty
  a_bad1: assert property (p_bad1) else $error("bad command unflagged");
  property p_cancel;
    wv && pend != 2'd0 && d == 8'hff |=> !op_start.start;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel started op");
endmodule
bind flash_status_error_logic flash_status_error_logic_properties u_props (.sys_clk, .sys_rst,
  .cmd_write, .op_done, .op_fail, .op_start, .sequencer_status_byte, .flash_control_reg_a);
`default_nettype wire

/* tb/flash_engine_model.sv */
/*
  model of the flash array engine: answers each start after LAT cycles.
  assumes fail_next is set by the bench before the start.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_engine_model #(
  parameter int LAT = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire flash_status_pkg::op_start_t op_start,
  input wire logic fail_next,
  output logic op_done,
  output logic op_fail
);
  int cnt;
  always_ff @(posedge sys_clk) begin
    op_done <= 1'b0;
    if (sys_rst) cnt <= 0;
    else if (op_start.start) cnt <= LAT;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      op_done <= cnt == 1;
    end
  end
  // outside done the fail line shows the inverse
  assign op_fail = op_done ? fail_next : ~fail_next;
endmodule
`default_nettype wire

/* tb/flash_status_error_logic_tb.sv */
/*
  testbench of the flash status and error logic.
  assumes the engine model as the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_status_error_logic_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  flash_status_pkg::bus_write_t cw = '0;
  logic rq = 1'b0;
  logic rw_en = 1'b1;
  logic lock0 = 1'b0;
  logic lock1 = 1'b0;
  logic ewa = 1'b1;
  logic urom = 1'b1;
  logic [15:0] wa = 16'h0100;
  logic is_fl = 1'b1;
  logic [1:0] blk = 2'd2;
  logic fail = 1'b0;
  logic done, ofail, busy;
  flash_status_pkg::op_start_t ost;
  logic [7:0] rdat, st;
  flash_status_pkg::status_mirror_t mir;
  int err_count = 0;
  int checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  flash_status_error_logic dut (.sys_clk, .sys_rst, .cmd_write(cw), .read_req(rq),
    .read_addr(16'h0100), .read_addr_user_rom(urom), .array_data(8'h5a),
    .erase_write_mode_a(ewa), .rewrite_enable_bit(rw_en), .block0_rewrite_lock(lock0),
    .block1_rewrite_lock(lock1), .target_is_flash(is_fl), .target_block(blk),
    .op_done(done), .op_fail(ofail), .op_start(ost), .read_data(rdat),
    .sequencer_status_byte(st), .flash_control_reg_a(mir), .cmd_busy(busy));
  flash_engine_model eng (.sys_clk, .sys_rst, .op_start(ost), .fail_next(fail),
    .op_done(done), .op_fail(ofail));
  task chk(input string n, input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [7:0] d);
    @(negedge sys_clk) cw = '{1'b1, wa, d};
    @(negedge sys_clk) cw.valid = 1'b0;
  endtask
  task rd(input logic [7:0] e);
    @(negedge sys_clk) rq = 1'b1;
    @(negedge sys_clk) rq = 1'b0;
    chk("read", rdat, e);
  endtask
  task stat(input logic [7:0] e);
    @(negedge sys_clk);
    chk("status", st, e);
  endtask
  task fin;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge sys_clk);
    chk("busy", {7'h0, busy}, 8'h00);
  endtask
  task t_reset;
    chk("status", st, 8'h80);
    chk("busy", {7'h0, busy}, 8'h00);
    chk("mirror", {5'h0, mir}, 8'h01);
  endtask
  task t_erase(input logic f, input logic [7:0] e);
    fail = f;
    wr(8'h20);
    wr(8'hd0);
    chk("start", {ost.start, 5'h0, ost.kind}, {1'b1, 5'h0, flash_status_pkg::OP_ERASE});
    stat(8'h00);
    rd(8'h00);
    fin;
    stat(e);
  endtask
  task t_refuse;
    wr(8'h40);
    wr(8'h70);
    stat(8'ha0);
    wr(8'h50);
    stat(8'h80);
  endtask
  task t_prog;
    fail = 1'b1;
    wr(8'h40);
    wr(8'h3c);
    chk("start", {ost.start, 5'h0, ost.kind}, {1'b1, 5'h0, flash_status_pkg::OP_PROGRAM});
    chk("prog data", ost.data, 8'h3c);
    chk("prog addr", ost.addr[7:0], wa[7:0]);
    fin;
    stat(8'h90);
    rd(8'h90);
    wr(8'hff);
    rd(8'h5a);
    wr(8'h50);
  endtask
  task t_bad;
    wr(8'h20);
    wr(8'h33);
    stat(8'hb0);
    wr(8'h50);
    wr(8'h11);
    stat(8'hb0);
    wr(8'h50);
    wr(8'h40);
    wa = 16'h0102;
    wr(8'h55);
    wa = 16'h0100;
    stat(8'hb0);
    wr(8'h50);
  endtask
  task t_cancel;
    wr(8'h70);
    rd(8'h80);
    urom = 1'b0;
    rd(8'h5a);
    urom = 1'b1;
    ewa = 1'b0;
    rd(8'h5a);
    ewa = 1'b1;
    wr(8'h20);
    wr(8'hff);
    stat(8'h80);
    rd(8'h5a);
  endtask
  task t_lock;
    rw_en = 1'b0;
    blk = 2'd0;
    wr(8'h40);
    wr(8'h12);
    stat(8'hb0);
    wr(8'h50);
    rw_en = 1'b1;
    lock0 = 1'b1;
    wr(8'h20);
    wr(8'hd0);
    stat(8'hb0);
    wr(8'h50);
    lock0 = 1'b0;
    blk = 2'd1;
    lock1 = 1'b1;
    wr(8'h40);
    wr(8'h12);
    stat(8'hb0);
    wr(8'h50);
    lock1 = 1'b0;
    blk = 2'd2;
    is_fl = 1'b0;
    wr(8'h20);
    wr(8'hd0);
    stat(8'hb0);
    is_fl = 1'b1;
    wr(8'h50);
    stat(8'h80);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    t_reset;
    t_erase(1'b0, 8'h80);
    t_erase(1'b1, 8'ha0);
    t_refuse;
    t_prog;
    t_bad;
    t_cancel;
    t_lock;
    summarize;
  end
  initial begin
    #500000;
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire
